// ### rtl/vio_cmd_unit.sv
// Behaviour
// - Output-off releases selected active-low output to open circuit.
// - Unknown output identifier returns invalid-identifier error, outputs unchanged.
// - Output-off reports 1 on success, 2 for an unknown output identifier.
// - Reverse override commands act only when source select equals 1.
// - With source select 1 and no command yet, override flag is off.
// - Override off stops reverse, resumes control after startup check if enabled.
// - Override enable and disable return 1 on success, 0 otherwise.
// - Interlock on lets throttle value pass.
// - Interlock off blocks throttle value.
// - With main contactor used, interlock set requests contactor closed.
// - With main contactor used, interlock clear requests contactor open.
// - Interlock commands act only with source select 1; default off.
// - Pot thresholds above 400 counts return parameter-range error.
// - Thresholds are scaled at 64 counts per volt.
// - Default thresholds by pot type; type 2 has no low threshold. Code uses VIO_DEF_LOW and VIO_DEF_HIGH for every type.
// - Type 5 takes thresholds from setup; one-wire has no low threshold.
// - On pot fault, configured fault value replaces the pot input.
// - Only throttle or brake selector accepted; success returns 1.
// - With lift enable on, pump start drives contactor on driver 3.
// - With lift enable on, pump stop switches contactor off.
// - With lift enable on and no pump command, contactor stays off.
// - Output-on drives output active and re-arms after overcurrent shutdown.
`timescale 1ns/1ps
`default_nettype none

module vio_cmd_unit
  import vio_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Command request
  input  wire logic                cmd_valid,
  input  wire vio_pkg::vio_cmd_t   cmd_code,
  input  wire logic [3:0]          output_selector,
  input  wire logic [1:0]          pot_selector,
  input  wire logic [8:0]          pot_low_arg,
  input  wire logic [8:0]          pot_high_arg,
  input  wire logic [14:0]         pot_fault_value_arg,
  // Command answer
  output logic                     rsp_valid,
  output logic [1:0]               rsp_code,
  // Configuration
  input  wire logic [1:0]          reverse_override_source_select,
  input  wire logic [1:0]          interlock_source_select,
  input  wire logic                main_contactor_use_enable,
  input  wire logic                lift_contactor_use_enable,
  input  wire logic                startup_inhibit_enable,
  input  wire logic [2:0]          throttle_pot_type,
  input  wire logic [1:0]          throttle_pot_wires,
  input  wire logic [2:0]          brake_pot_type,
  input  wire logic [1:0]          brake_pot_wires,
  // Low-power outputs, active low, open drain
  input  wire logic                overcurrent_a,
  input  wire logic                overcurrent_b,
  output logic                     low_power_output_a_oe,
  output logic                     low_power_output_b_oe,
  // Emergency reverse
  output logic                     reverse_override_flag,
  output logic                     startup_check_request,
  input  wire logic                startup_check_done,
  output logic                     normal_control_active,
  // Interlock and throttle path
  input  wire logic [14:0]         throttle_in,
  output logic                     interlock_flag,
  output logic [14:0]              throttle_out,
  output logic                     main_close_request,
  output logic                     main_open_request,
  // Pot inputs
  input  wire logic [8:0]          throttle_wiper,
  input  wire logic [8:0]          brake_wiper,
  input  wire logic [14:0]         brake_in,
  output logic                     throttle_pot_fault,
  output logic                     brake_pot_fault,
  output logic [14:0]              brake_out,
  // Pump lift contactor
  output logic                     pump_driver3_on
);
  import vio_pkg::*;

  // ---------------------------------------------------------------------------
  // Overcurrent pin synchronisers
  // ---------------------------------------------------------------------------
  // Three stages; a change is taken once stages two and three agree.
  logic [2:0] oc_a_q, oc_b_q;
  logic       oc_a_d3, oc_b_d3;
  logic       oc_a_st_q, oc_b_st_q;
  logic       oc_a_st_d, oc_b_st_d;

  always_comb begin
    oc_a_d3   = oc_a_q[1];
    oc_b_d3   = oc_b_q[1];
    oc_a_st_d = (oc_a_q[1] == oc_a_q[2]) ? oc_a_q[2] : oc_a_st_q;
    oc_b_st_d = (oc_b_q[1] == oc_b_q[2]) ? oc_b_q[2] : oc_b_st_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oc_a_q    <= 3'h0;
      oc_b_q    <= 3'h0;
      oc_a_st_q <= 1'b0;
      oc_b_st_q <= 1'b0;
    end else begin
      oc_a_q    <= {oc_a_d3, oc_a_q[0], overcurrent_a};
      oc_b_q    <= {oc_b_d3, oc_b_q[0], overcurrent_b};
      oc_a_st_q <= oc_a_st_d;
      oc_b_st_q <= oc_b_st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Command state
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VIO_REV_OFF,
    VIO_REV_ON,
    VIO_REV_CHECK
  } vio_rev_state_t;

  logic           out_a_on_q, out_a_on_d;
  logic           out_b_on_q, out_b_on_d;
  logic           oc_a_trip_q, oc_a_trip_d;
  logic           oc_b_trip_q, oc_b_trip_d;
  vio_rev_state_t rev_q, rev_d;
  logic           lock_q, lock_d;
  logic           close_q, close_d;
  logic           open_q, open_d;
  logic           pump_q, pump_d;
  logic           rsp_valid_q, rsp_valid_d;
  logic [1:0]     rsp_code_q, rsp_code_d;
  logic           thr_cfg_q, thr_cfg_d;
  logic           brk_cfg_q, brk_cfg_d;
  logic [8:0]     thr_low_q, thr_low_d, thr_high_q, thr_high_d;
  logic [8:0]     brk_low_q, brk_low_d, brk_high_q, brk_high_d;
  logic [14:0]    thr_fv_q, thr_fv_d, brk_fv_q, brk_fv_d;
  logic [14:0]    throttle_out_q, throttle_out_d;
  logic           range_ok;
  logic [14:0]    throttle_out_pot;

  always_comb begin
    out_a_on_d  = out_a_on_q;
    out_b_on_d  = out_b_on_q;
    oc_a_trip_d = oc_a_trip_q | (out_a_on_q & oc_a_st_q);
    oc_b_trip_d = oc_b_trip_q | (out_b_on_q & oc_b_st_q);
    rev_d       = rev_q;
    lock_d      = lock_q;
    close_d     = 1'b0;
    open_d      = 1'b0;
    pump_d      = pump_q;
    rsp_valid_d = 1'b0;
    rsp_code_d  = rsp_code_q;
    thr_cfg_d   = thr_cfg_q;
    brk_cfg_d   = brk_cfg_q;
    thr_low_d   = thr_low_q;
    thr_high_d  = thr_high_q;
    thr_fv_d    = thr_fv_q;
    brk_low_d   = brk_low_q;
    brk_high_d  = brk_high_q;
    brk_fv_d    = brk_fv_q;
    range_ok    = (pot_low_arg <= VIO_THR_MAX) &&
                  (pot_high_arg <= VIO_THR_MAX);
    // Startup check finishes the return to normal control.
    if (rev_q == VIO_REV_CHECK && startup_check_done) begin
      rev_d = VIO_REV_OFF;
    end
    if (cmd_valid) begin
      rsp_valid_d = 1'b1;
      rsp_code_d  = VIO_RES_FAIL;
      unique case (cmd_code)
        VIO_CMD_OUT_ON, VIO_CMD_OUT_OFF: begin
          if (output_selector == VIO_OUT_ID_A) begin
            out_a_on_d  = (cmd_code == VIO_CMD_OUT_ON);
            // A trip raised in this same cycle wins over the re-arm.
            oc_a_trip_d = out_a_on_q & oc_a_st_q;
            rsp_code_d  = VIO_RES_OK;
          end else if (output_selector == VIO_OUT_ID_B) begin
            out_b_on_d  = (cmd_code == VIO_CMD_OUT_ON);
            oc_b_trip_d = out_b_on_q & oc_b_st_q;
            rsp_code_d  = VIO_RES_OK;
          end else begin
            rsp_code_d  = VIO_RES_INVALID_IDENTIFIER_ERROR;
          end
        end
        VIO_CMD_REV_ENABLE: begin
          if (reverse_override_source_select == VIO_SRC_SEL_CMD) begin
            rev_d      = VIO_REV_ON;
            rsp_code_d = VIO_RES_OK;
          end
        end
        VIO_CMD_REV_DISABLE: begin
          if (reverse_override_source_select == VIO_SRC_SEL_CMD) begin
            if (rev_q == VIO_REV_ON) begin
              rev_d = startup_inhibit_enable ? VIO_REV_CHECK
                                             : VIO_REV_OFF;
            end
            rsp_code_d = VIO_RES_OK;
          end
        end
        VIO_CMD_LOCK_SET, VIO_CMD_LOCK_CLEAR: begin
          if (interlock_source_select == VIO_SRC_SEL_CMD) begin
            lock_d     = (cmd_code == VIO_CMD_LOCK_SET);
            close_d    = main_contactor_use_enable &&
                         (cmd_code == VIO_CMD_LOCK_SET);
            open_d     = main_contactor_use_enable &&
                         (cmd_code == VIO_CMD_LOCK_CLEAR);
            rsp_code_d = VIO_RES_OK;
          end
        end
        VIO_CMD_POT_FAULTS: begin
          if (pot_selector != VIO_POT_ID_THR &&
              pot_selector != VIO_POT_ID_BRK) begin
            rsp_code_d = VIO_RES_INVALID_IDENTIFIER_ERROR;
          end else if (!range_ok) begin
            rsp_code_d = VIO_RES_BAD_RANGE;
          end else if (pot_selector == VIO_POT_ID_THR) begin
            thr_cfg_d  = 1'b1;
            thr_low_d  = pot_low_arg;
            thr_high_d = pot_high_arg;
            thr_fv_d   = pot_fault_value_arg;
            rsp_code_d = VIO_RES_OK;
          end else begin
            brk_cfg_d  = 1'b1;
            brk_low_d  = pot_low_arg;
            brk_high_d = pot_high_arg;
            brk_fv_d   = pot_fault_value_arg;
            rsp_code_d = VIO_RES_OK;
          end
        end
        VIO_CMD_PUMP_START, VIO_CMD_PUMP_STOP: begin
          if (lift_contactor_use_enable) begin
            pump_d     = (cmd_code == VIO_CMD_PUMP_START);
            rsp_code_d = VIO_RES_OK;
          end
        end
        default: begin
          rsp_code_d = VIO_RES_FAIL;
        end
      endcase
    end
    // Pass only the throttle while the interlock holds.
    throttle_out_d = lock_q ? throttle_out_pot : 15'h0000;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_a_on_q     <= 1'b0;
      out_b_on_q     <= 1'b0;
      oc_a_trip_q    <= 1'b0;
      oc_b_trip_q    <= 1'b0;
      rev_q          <= VIO_REV_OFF;
      lock_q         <= 1'b0;
      close_q        <= 1'b0;
      open_q         <= 1'b0;
      pump_q         <= 1'b0;
      rsp_valid_q    <= 1'b0;
      rsp_code_q     <= VIO_RES_FAIL;
      thr_cfg_q      <= 1'b0;
      brk_cfg_q      <= 1'b0;
      thr_low_q      <= VIO_DEF_LOW;
      thr_high_q     <= VIO_DEF_HIGH;
      thr_fv_q       <= VIO_DEF_FVAL;
      brk_low_q      <= VIO_DEF_LOW;
      brk_high_q     <= VIO_DEF_HIGH;
      brk_fv_q       <= VIO_DEF_FVAL;
      throttle_out_q <= 15'h0000;
    end else begin
      out_a_on_q     <= out_a_on_d;
      out_b_on_q     <= out_b_on_d;
      oc_a_trip_q    <= oc_a_trip_d;
      oc_b_trip_q    <= oc_b_trip_d;
      rev_q          <= rev_d;
      lock_q         <= lock_d;
      close_q        <= close_d;
      open_q         <= open_d;
      pump_q         <= pump_d;
      rsp_valid_q    <= rsp_valid_d;
      rsp_code_q     <= rsp_code_d;
      thr_cfg_q      <= thr_cfg_d;
      brk_cfg_q      <= brk_cfg_d;
      thr_low_q      <= thr_low_d;
      thr_high_q     <= thr_high_d;
      thr_fv_q       <= thr_fv_d;
      brk_low_q      <= brk_low_d;
      brk_high_q     <= brk_high_d;
      brk_fv_q       <= brk_fv_d;
      throttle_out_q <= throttle_out_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Pot fault monitors
  // ---------------------------------------------------------------------------
  // Unconfigured pots use the defaults; a one-wire type 5 or a type 2 pot
  // has no low threshold, so only the high limit can trip it.
  vio_pot_if   thr_pot ();
  vio_pot_if   brk_pot ();

  always_comb begin
    thr_pot.low_thr     = thr_cfg_q ? thr_low_q : VIO_DEF_LOW;
    thr_pot.high_thr    = thr_cfg_q ? thr_high_q : VIO_DEF_HIGH;
    thr_pot.low_used    = !(throttle_pot_type == VIO_POT_TYPE_2 ||
                            (throttle_pot_type == VIO_POT_TYPE_5 &&
                             throttle_pot_wires == VIO_WIRE_ONE));
    thr_pot.fault_value = thr_fv_q;
    thr_pot.wiper       = throttle_wiper;
    thr_pot.value_in    = throttle_in;
    brk_pot.low_thr     = brk_cfg_q ? brk_low_q : VIO_DEF_LOW;
    brk_pot.high_thr    = brk_cfg_q ? brk_high_q : VIO_DEF_HIGH;
    brk_pot.low_used    = !(brake_pot_type == VIO_POT_TYPE_2 ||
                            (brake_pot_type == VIO_POT_TYPE_5 &&
                             brake_pot_wires == VIO_WIRE_ONE));
    brk_pot.fault_value = brk_fv_q;
    brk_pot.wiper       = brake_wiper;
    brk_pot.value_in    = brake_in;
  end

  assign throttle_out_pot = thr_pot.value_out;

  vio_pot_mon u_thr_mon (
    .clk    (clk),
    .resetn (resetn),
    .pot    (thr_pot)
  );

  vio_pot_mon u_brk_mon (
    .clk    (clk),
    .resetn (resetn),
    .pot    (brk_pot)
  );

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // The pin is pulled low only while on and not tripped by overcurrent.
  assign low_power_output_a_oe = out_a_on_q & ~oc_a_trip_q;
  assign low_power_output_b_oe = out_b_on_q & ~oc_b_trip_q;
  assign reverse_override_flag = (rev_q == VIO_REV_ON);
  assign startup_check_request = (rev_q == VIO_REV_CHECK);
  assign normal_control_active = (rev_q == VIO_REV_OFF);
  assign interlock_flag        = lock_q;
  assign throttle_out          = throttle_out_q;
  assign main_close_request    = close_q;
  assign main_open_request     = open_q;
  assign throttle_pot_fault    = thr_pot.fault;
  assign brake_pot_fault       = brk_pot.fault;
  assign brake_out             = brk_pot.value_out;
  assign pump_driver3_on       = pump_q;
  assign rsp_valid             = rsp_valid_q;
  assign rsp_code              = rsp_code_q;

endmodule

`default_nettype wire

// ### rtl/vio_pkg.sv
package vio_pkg;

  // ---------------------------------------------------------------------------
  // Command opcodes
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    VIO_CMD_OUT_ON       = 4'h1,
    VIO_CMD_OUT_OFF      = 4'h2,
    VIO_CMD_REV_ENABLE   = 4'h3,
    VIO_CMD_REV_DISABLE  = 4'h4,
    VIO_CMD_LOCK_SET     = 4'h5,
    VIO_CMD_LOCK_CLEAR   = 4'h6,
    VIO_CMD_POT_FAULTS   = 4'h7,
    VIO_CMD_PUMP_START   = 4'h8,
    VIO_CMD_PUMP_STOP    = 4'h9
  } vio_cmd_t;

  // ---------------------------------------------------------------------------
  // Result codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] VIO_RES_FAIL      = 2'h0;
  localparam logic [1:0] VIO_RES_OK        = 2'h1;
  localparam logic [1:0] VIO_RES_INVALID_IDENTIFIER_ERROR    = 2'h2;
  localparam logic [1:0] VIO_RES_BAD_RANGE = 2'h3;

  // ---------------------------------------------------------------------------
  // Identifiers and configuration values
  // ---------------------------------------------------------------------------
  localparam logic [3:0] VIO_OUT_ID_A      = 4'h6;
  localparam logic [3:0] VIO_OUT_ID_B      = 4'h7;
  localparam logic [1:0] VIO_POT_ID_THR    = 2'h0;
  localparam logic [1:0] VIO_POT_ID_BRK    = 2'h1;
  localparam logic [1:0] VIO_SRC_SEL_CMD   = 2'h1;
  localparam logic [2:0] VIO_POT_TYPE_2    = 3'h2;
  localparam logic [2:0] VIO_POT_TYPE_5    = 3'h5;
  localparam logic [1:0] VIO_WIRE_ONE      = 2'h1;
  localparam int         VIO_PUMP_DRIVER   = 3;

  // ---------------------------------------------------------------------------
  // Potentiometer scaling, 64 counts per volt
  // ---------------------------------------------------------------------------
  localparam int          VIO_COUNTS_PER_V = 64;
  localparam logic [8:0]  VIO_THR_MAX      = 9'h190;
  localparam logic [8:0]  VIO_DEF_LOW      = 9'h006;
  localparam logic [8:0]  VIO_DEF_HIGH     = 9'h160;
  localparam logic [14:0] VIO_DEF_FVAL     = 15'h0000;
  localparam logic [14:0] VIO_FULL_SCALE   = 15'h7fff;

endpackage

// ### rtl/vio_pot_if.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------------
// Per-pot threshold set and fault report
// ---------------------------------------------------------------------------
interface vio_pot_if;
  logic [8:0]  low_thr;
  logic        low_used;
  logic [8:0]  high_thr;
  logic [14:0] fault_value;
  logic [8:0]  wiper;
  logic [14:0] value_in;
  logic        fault;
  logic [14:0] value_out;

  modport ctrl (output low_thr, output low_used, output high_thr,
                output fault_value, output wiper, output value_in,
                input fault, input value_out);
  modport mon  (input low_thr, input low_used, input high_thr,
                input fault_value, input wiper, input value_in,
                output fault, output value_out);
endinterface

`default_nettype wire

// ### rtl/vio_pot_mon.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------------
// Wiper fault monitor for one pot input
// ---------------------------------------------------------------------------
module vio_pot_mon
  import vio_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Threshold set and samples
  vio_pot_if.mon    pot
);

  logic        fault_d;
  logic        fault_q;
  logic [14:0] value_d;
  logic [14:0] value_q;

  always_comb begin
    fault_d = (pot.low_used && (pot.wiper < pot.low_thr)) ||
              (pot.wiper > pot.high_thr);
    value_d = fault_d ? pot.fault_value : pot.value_in;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_q <= 1'b0;
      value_q <= 15'h0000;
    end else begin
      fault_q <= fault_d;
      value_q <= value_d;
    end
  end

  assign pot.fault     = fault_q;
  assign pot.value_out = value_q;

endmodule

`default_nettype wire

// ### tb/vio_app_model.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------
// Application program: one command at a time
// --------------------------------------------------------------
module vio_app_model
  import vio_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rsp_valid,
  input  wire logic [1:0]         rsp_code,
  output var  logic               cmd_valid,
  output var  vio_pkg::vio_cmd_t  cmd_code,
  output var  logic [3:0]         output_selector,
  output var  logic [1:0]         pot_selector,
  output var  logic [8:0]         pot_low_arg,
  output var  logic [8:0]         pot_high_arg,
  output var  logic [14:0]        pot_fault_value_arg
);
  logic [1:0] answer;

  initial begin
    cmd_valid = 1'b0;
    cmd_code = VIO_CMD_OUT_ON;
    {output_selector, pot_selector, pot_low_arg} = '0;
    {pot_high_arg, pot_fault_value_arg} = '0;
  end

  // Arguments are inverted once a command is gone, so a unit that
  // samples them late sees garbage instead of a lucky stale value.
  task automatic issue(input vio_cmd_t c, input logic [3:0] os,
                       input logic [1:0] ps, input logic [8:0] lo,
                       input logic [8:0] hi, input logic [14:0] fv);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    {output_selector, pot_selector, pot_low_arg} = {os, ps, lo};
    {pot_high_arg, pot_fault_value_arg} = {hi, fv};
    @(negedge clk);
    cmd_valid = 1'b0;
    answer = rsp_valid ? rsp_code : 2'bxx;
    {output_selector, pot_selector, pot_low_arg} = ~{os, ps, lo};
    {pot_high_arg, pot_fault_value_arg} = ~{hi, fv};
  endtask
endmodule

`default_nettype wire

// ### tb/vio_cmd_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------
// Port checker for the command unit
// --------------------------------------------------------------
module vio_cmd_monitor
  import vio_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // Command and answer
  input wire logic              cmd_valid,
  input wire vio_pkg::vio_cmd_t cmd_code,
  input wire logic [3:0]        output_selector,
  input wire logic [1:0]        pot_selector,
  input wire logic [8:0]        pot_high_arg,
  input wire logic              rsp_valid,
  input wire logic [1:0]        rsp_code,
  // Configuration
  input wire logic [1:0]        reverse_override_source_select,
  input wire logic [1:0]        interlock_source_select,
  input wire logic              main_contactor_use_enable,
  input wire logic              lift_contactor_use_enable,
  // State
  input wire logic              reverse_override_flag,
  input wire logic              interlock_flag,
  input wire logic [14:0]       throttle_out,
  input wire logic              main_close_request,
  input wire logic              main_open_request,
  input wire logic              pump_driver3_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wire logic rev_cmd  = cmd_valid && (cmd_code == VIO_CMD_REV_ENABLE ||
                                      cmd_code == VIO_CMD_REV_DISABLE);
  wire logic lock_cmd = cmd_valid && (cmd_code == VIO_CMD_LOCK_SET ||
                                      cmd_code == VIO_CMD_LOCK_CLEAR);
  wire logic lock_sel = interlock_source_select == VIO_SRC_SEL_CMD;
  wire logic main_use = main_contactor_use_enable && lock_sel;

  property p_answer; cmd_valid |=> rsp_valid; endproperty
  a_answer: assert property (p_answer)
    else $error("answer missing");
  property p_quiet; !cmd_valid |=> !rsp_valid; endproperty
  a_quiet: assert property (p_quiet)
    else $error("answer without command");
  property p_badout;
    cmd_valid && cmd_code == VIO_CMD_OUT_OFF &&
    output_selector != VIO_OUT_ID_A && output_selector != VIO_OUT_ID_B
    |=> rsp_code == VIO_RES_INVALID_IDENTIFIER_ERROR;
  endproperty
  a_badout: assert property (p_badout)
    else $error("bad output id accepted");
  property p_range;
    cmd_valid && cmd_code == VIO_CMD_POT_FAULTS && pot_selector < 2'h2 &&
    pot_high_arg > VIO_THR_MAX |=> rsp_code == VIO_RES_BAD_RANGE;
  endproperty
  a_range: assert property (p_range)
    else $error("threshold range not refused");
  property p_close;
    cmd_valid && cmd_code == VIO_CMD_LOCK_SET && main_use
    |=> main_close_request && interlock_flag;
  endproperty
  a_close: assert property (p_close)
    else $error("close request missing");
  property p_open;
    cmd_valid && cmd_code == VIO_CMD_LOCK_CLEAR && main_use
    |=> main_open_request && !interlock_flag;
  endproperty
  a_open: assert property (p_open)
    else $error("open request missing");
  property p_block; !interlock_flag [*2] |-> throttle_out == 15'h0000;
  endproperty
  a_block: assert property (p_block)
    else $error("throttle passed while locked out");
  property p_revsel;
    rev_cmd && reverse_override_source_select != VIO_SRC_SEL_CMD
    |=> rsp_code == VIO_RES_FAIL && $stable(reverse_override_flag);
  endproperty
  a_revsel: assert property (p_revsel)
    else $error("reverse command acted when not selected");
  property p_locksel;
    lock_cmd && !lock_sel
    |=> rsp_code == VIO_RES_FAIL && $stable(interlock_flag);
  endproperty
  a_locksel: assert property (p_locksel)
    else $error("interlock command acted when not selected");
  property p_pump;
    cmd_valid && cmd_code == VIO_CMD_PUMP_START && lift_contactor_use_enable
    |=> pump_driver3_on && rsp_code == VIO_RES_OK;
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump did not start");
endmodule

bind vio_cmd_unit vio_cmd_monitor u_mon (.*);

`default_nettype wire

// ### tb/vio_cmd_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module vio_cmd_unit_tb;
  import vio_pkg::*;
  int n_mismatch = 0, checked = 0;
  logic clk = 1'b0, resetn = 1'b0;
  logic cmd_valid, rsp_valid;
  vio_cmd_t cmd_code;
  logic [3:0] output_selector;
  logic [1:0] pot_selector, rsp_code;
  logic [8:0] pot_low_arg, pot_high_arg;
  logic [14:0] pot_fault_value_arg, throttle_out, brake_out;
  logic [1:0] reverse_override_source_select = 2'h1;
  logic [1:0] interlock_source_select = 2'h1;
  logic main_contactor_use_enable = 1'b0, lift_contactor_use_enable = 1'b1;
  logic startup_inhibit_enable = 1'b0, startup_check_done = 1'b0;
  logic [2:0] throttle_pot_type = 3'h5, brake_pot_type = 3'h2;
  logic [1:0] throttle_pot_wires = 2'h3, brake_pot_wires = 2'h0;
  logic overcurrent_a = 1'b0, overcurrent_b = 1'b0;
  logic [14:0] throttle_in = 15'h1a2b, brake_in = 15'h0555;
  logic [8:0] throttle_wiper = 9'h080, brake_wiper = 9'h080;
  logic low_power_output_a_oe, low_power_output_b_oe, pump_driver3_on;
  logic reverse_override_flag, startup_check_request, normal_control_active;
  logic interlock_flag, main_close_request, main_open_request;
  logic throttle_pot_fault, brake_pot_fault;
  logic [8:0] tw [4] = '{9'h012, 9'h141, 9'h140, 9'h013};
  logic [3:0] tf = 4'b1100;
  logic [8:0] bw [5] = '{9'h000, 9'h161, 9'h005, 9'h006, 9'h160};
  logic [2:0] bt [5] = '{3'h2, 3'h2, 3'h1, 3'h1, 3'h1};
  logic [4:0] bf = 5'b01100;

  always #4 clk = ~clk;

  vio_app_model app (.*);

  vio_cmd_unit uut (.*);

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic run(input vio_cmd_t c, input logic [1:0] e,
                     input logic [3:0] os = 4'h6, input logic [1:0] ps = 2'h0,
                     input logic [8:0] lo = 9'h000,
                     input logic [8:0] hi = 9'h000,
                     input logic [14:0] fv = 15'h0000);
    app.issue(c, os, ps, lo, hi, fv);
    `CHK("answer", e, app.answer)
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    cyc(10);
    resetn = 1'b1;
    cyc(1);
    `CHK("rev", 1'b0, reverse_override_flag)
    `CHK("lock", 1'b0, interlock_flag)
    `CHK("pump", 1'b0, pump_driver3_on)
    run(VIO_CMD_OUT_ON, VIO_RES_OK, VIO_OUT_ID_B);
    run(VIO_CMD_OUT_OFF, VIO_RES_INVALID_IDENTIFIER_ERROR, 4'h8);
    run(VIO_CMD_OUT_OFF, VIO_RES_INVALID_IDENTIFIER_ERROR, 4'h5);
    `CHK("out_b", 1'b1, low_power_output_b_oe)
    run(VIO_CMD_OUT_OFF, VIO_RES_OK, VIO_OUT_ID_B);
    `CHK("out_b", 1'b0, low_power_output_b_oe)
    run(VIO_CMD_OUT_ON, VIO_RES_OK, VIO_OUT_ID_A);
    overcurrent_a = 1'b1;
    cyc(8);
    `CHK("trip_a", 1'b0, low_power_output_a_oe)
    overcurrent_a = 1'b0;
    cyc(4);
    run(VIO_CMD_OUT_ON, VIO_RES_OK, VIO_OUT_ID_A);
    `CHK("out_a", 1'b1, low_power_output_a_oe)
    reverse_override_source_select = 2'h2;
    run(VIO_CMD_REV_ENABLE, VIO_RES_FAIL);
    reverse_override_source_select = 2'h1;
    run(VIO_CMD_REV_ENABLE, VIO_RES_OK);
    `CHK("rev", 1'b1, reverse_override_flag)
    startup_inhibit_enable = 1'b1;
    run(VIO_CMD_REV_DISABLE, VIO_RES_OK);
    `CHK("check", 1'b1, startup_check_request)
    `CHK("normal", 1'b0, normal_control_active)
    startup_check_done = 1'b1;
    for (int i = 0; i < 8 && normal_control_active !== 1'b1; i++)
      cyc(1);
    `CHK("normal", 1'b1, normal_control_active)
    interlock_source_select = 2'h0;
    run(VIO_CMD_LOCK_SET, VIO_RES_FAIL);
    interlock_source_select = 2'h1;
    main_contactor_use_enable = 1'b1;
    run(VIO_CMD_LOCK_SET, VIO_RES_OK);
    cyc(3);
    `CHK("thr", 15'h1a2b, throttle_out)
    run(VIO_CMD_POT_FAULTS, VIO_RES_INVALID_IDENTIFIER_ERROR, 4'h6, 2'h2, 9'h013);
    run(VIO_CMD_POT_FAULTS, VIO_RES_BAD_RANGE, 4'h6, 2'h0, 9'h013,
        9'h191);
    run(VIO_CMD_POT_FAULTS, VIO_RES_OK, 4'h6, 2'h0, 9'h000, 9'h190);
    run(VIO_CMD_POT_FAULTS, VIO_RES_OK, 4'h6, 2'h0, 9'h013, 9'h140,
        15'h0fa0);
    foreach (tw[i]) begin
      throttle_wiper = tw[i];
      cyc(3);
      `CHK("t_fault", tf[3-i], throttle_pot_fault)
      `CHK("thr", tf[3-i] ? 15'h0fa0 : 15'h1a2b, throttle_out)
    end
    foreach (bw[i]) begin
      brake_pot_type = bt[i];
      brake_wiper = bw[i];
      cyc(3);
      `CHK("b_fault", bf[4-i], brake_pot_fault)
      `CHK("brake", bf[4-i] ? 15'h0000 : 15'h0555, brake_out)
    end
    run(VIO_CMD_LOCK_CLEAR, VIO_RES_OK);
    cyc(3);
    `CHK("thr", 15'h0000, throttle_out)
    lift_contactor_use_enable = 1'b0;
    run(VIO_CMD_PUMP_START, VIO_RES_FAIL);
    `CHK("pump", 1'b0, pump_driver3_on)
    lift_contactor_use_enable = 1'b1;
    run(VIO_CMD_PUMP_START, VIO_RES_OK);
    `CHK("pump", 1'b1, pump_driver3_on)
    run(VIO_CMD_PUMP_STOP, VIO_RES_OK);
    `CHK("pump", 1'b0, pump_driver3_on)
    close_out();
  end
endmodule

`default_nettype wire
